// >>> core/rtcc_consts.svh
// Register indices, field positions and reset values of the RTC control block
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define RTCC_IDX_BUF0 6'h00
`define RTCC_IDX_BUF3 6'h03
`define RTCC_IDX_CTRL 6'h04
`define RTCC_IDX_OSC 6'h05
`define RTCC_IDX_ALM0 6'h08
`define RTCC_IDX_ALM3 6'h0b
`define RTCC_IDX_IRQ_STAT 6'h10
`define RTCC_IDX_IRQ_CLR 6'h11
`define RTCC_IDX_IRQ_EN 6'h12

// ----------------------------------------------------------------
// Main control field positions
// ----------------------------------------------------------------
`define RTCC_CTRL_OSC_EN 7
`define RTCC_CTRL_MISS_EN 6
`define RTCC_CTRL_OSC_FAIL 5
`define RTCC_CTRL_RUN 4
`define RTCC_CTRL_ALARM_EN 3
`define RTCC_CTRL_ALARM_FLAG 2
`define RTCC_CTRL_LOAD 1
`define RTCC_CTRL_SNAP 0

// ----------------------------------------------------------------
// Oscillator control field positions and reset
// ----------------------------------------------------------------
`define RTCC_OSC_AGC 7
`define RTCC_OSC_MODE 6
`define RTCC_OSC_BIAS 5
`define RTCC_OSC_AMPV 4
`define RTCC_OSC_RST 8'h00

// ----------------------------------------------------------------
// Interrupt event positions and reset
// ----------------------------------------------------------------
`define RTCC_EVT_ALARM 0
`define RTCC_EVT_FAIL 1
`define RTCC_EVT_LOAD 2
`define RTCC_EVT_SNAP 3
`define RTCC_EVT_W 4
`define RTCC_IRQ_EN_RST 4'h0

`endif

// >>> core/rtcc_pkg.sv
// Types shared by the RTC control block
package rtcc_pkg;

  // ----------------------------------------------------------------
  // Whole state of the control core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] timer;      // Running timer
    logic [31:0] xfer_buf;   // Transfer buffer for load and snapshot
    logic [31:0] alarm_val;  // Alarm match value
    logic run;               // Timer run
    logic alarm_en;          // Alarm compare enable
    logic alarm_flag;        // Short alarm event flag
    logic auto_rst;          // Auto-reset enable, stored apart from the flag
    logic load_req;          // Timer load pending
    logic snap_req;          // Timer snapshot pending
    logic ar_pend;           // Auto-reset due at next tick
    logic osc_en;            // Oscillator enable
    logic miss_en;           // Missing-clock detector enable
    logic osc_fail;          // Oscillator fail flag
    logic agc_en;            // Gain control enable
    logic osc_mode_select;             // Crystal mode select
    logic bias_x2;           // Doubled bias enable
    logic [3:0] irq_stat;    // Sticky event bits
    logic [3:0] irq_en;      // Interrupt enables
    logic irq;               // Interrupt line
    logic tick_prev;         // Last synced tick level
    logic dp_wr;             // Write data phase pending
    logic [5:0] dp_idx;      // Register index of data phase
    logic [31:0] rdata;      // Read data
    logic ready;             // Bus ready
    logic resp;              // Bus response
  } rtcc_state_t;

endpackage

// >>> core/rtcc_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps

module rtcc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;  // First stage, read only by the second
    logic [WIDTH-1:0] s2;  // Second stage, safe to use
  } rtcc_sync_state_t;

  rtcc_sync_state_t st_reg;
  rtcc_sync_state_t st_next;

  // Refuse an empty group
  if (WIDTH < 1) begin : g_bad_width
    $error("rtcc_sync needs WIDTH of at least one");
  end

  // Shift both stages
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
  end

  // Register stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.s2;

endmodule

// >>> core/rtcc_core.sv
// RTC timer control, alarm and oscillator control registers on AHB-Lite
//
// Behaviour
// - Run bit lets timer count; clear holds
// - Alarm enable gates compare; writing clears flag
// - Bit 2 reads flag, writes auto-reset
// - Load request copies buffer into timer
// - Snapshot request copies timer into buffer
// - Alarm flag lasts at most one tick
// - Fail flag undefined while oscillator disabled
// - Gain control enable bit drives oscillator
// - Mode bit selects self-oscillate or crystal
// - Bias double bit doubles oscillator bias
// - Amplitude valid bit shows oscillation sufficient
// - Oscillator control low nibble reads zero
// - Alarm when timer becomes equal to match
// - Auto-reset zeroes timer one tick later
// - Transfer buffer bit 0 is timer bit 0
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
`include "rtcc_consts.svh"

module rtcc_core (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic RTC_TICK_I,
  input wire logic OSC_MISSING_I,
  input wire logic OSC_AMP_OK_I,
  output logic [31:0] TIMER_O,
  output logic ALARM_O,
  output logic OSC_EN_O,
  output logic MISS_DET_EN_O,
  output logic OSC_AGC_EN_O,
  output logic OSC_XTAL_MODE_O,
  output logic OSC_BIAS_X2_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // State and local signals
  // ----------------------------------------------------------------
  rtcc_pkg::rtcc_state_t s_reg;   // Registered state
  rtcc_pkg::rtcc_state_t s_next;  // Next state

  logic [2:0] sync_lvl;   // Synced tick, missing clock, amplitude ok
  logic tick;             // One-cycle pulse per RTC tick
  logic [31:0] t_next;    // Timer value after this tick
  logic alarm_hit;        // Alarm event at this tick
  logic addr_ok;          // Valid address phase taken
  logic [7:0] wd;         // Byte written in data phase
  logic wr_ctrl;          // Data phase writes main control
  logic wr_load;          // Write requests a load
  logic wr_snap;          // Write requests a snapshot
  logic [3:0] evt;        // Interrupt events raised this cycle
  logic [3:0] clr;        // Status bits cleared by software this cycle

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  // Tick and oscillator status come from the oscillator side, so all
  // three levels pass two flops before any logic looks at them.
  rtcc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .async_i({OSC_AMP_OK_I, OSC_MISSING_I, RTC_TICK_I}),
    .sync_o(sync_lvl)
  );

  // Rising edge of the synced tick
  assign tick = sync_lvl[0] & ~s_reg.tick_prev;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Builds the read word for one index; unmapped indices read zero
  function automatic logic [31:0] read_word(input logic [5:0] idx,
                                            input rtcc_pkg::rtcc_state_t st,
                                            input logic amp_ok);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (idx <= `RTCC_IDX_BUF3) begin
      r[7:0] = st.xfer_buf[idx[1:0]*8 +: 8];  // Byte 0 holds timer bit 0
    end else if (idx >= `RTCC_IDX_ALM0 && idx <= `RTCC_IDX_ALM3) begin
      r[7:0] = st.alarm_val[idx[1:0]*8 +: 8];
    end else if (idx == `RTCC_IDX_CTRL) begin
      r[`RTCC_CTRL_OSC_EN] = st.osc_en;
      r[`RTCC_CTRL_MISS_EN] = st.miss_en;
      r[`RTCC_CTRL_OSC_FAIL] = st.osc_fail;
      r[`RTCC_CTRL_RUN] = st.run;
      r[`RTCC_CTRL_ALARM_EN] = st.alarm_en;
      r[`RTCC_CTRL_ALARM_FLAG] = st.alarm_flag;  // Flag, not auto-reset
      r[`RTCC_CTRL_LOAD] = st.load_req;
      r[`RTCC_CTRL_SNAP] = st.snap_req;
    end else if (idx == `RTCC_IDX_OSC) begin
      r[`RTCC_OSC_AGC] = st.agc_en;
      r[`RTCC_OSC_MODE] = st.osc_mode_select;
      r[`RTCC_OSC_BIAS] = st.bias_x2;
      r[`RTCC_OSC_AMPV] = amp_ok;  // Live oscillator amplitude state
    end else if (idx == `RTCC_IDX_IRQ_STAT) begin
      r[3:0] = st.irq_stat;
    end else if (idx == `RTCC_IDX_IRQ_EN) begin
      r[3:0] = st.irq_en;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Timer step and alarm compare
  // ----------------------------------------------------------------
  // Priority at a tick: pending load, then pending auto-reset, then count
  always_comb begin
    t_next = s_reg.timer;
    if (s_reg.load_req) begin
      t_next = s_reg.xfer_buf;
    end else if (s_reg.ar_pend) begin
      t_next = 32'h0000_0000;
    end else if (s_reg.run) begin
      t_next = s_reg.timer + 32'h0000_0001;
    end
    // Only a change into the match value counts, so a stopped timer
    // sitting on the match does not fire again at every tick.
    alarm_hit = tick && s_reg.alarm_en && (t_next == s_reg.alarm_val)
                && (t_next != s_reg.timer);
  end

  // Data phase write decode
  assign wd = HWDATA_I[7:0];
  assign wr_ctrl = s_reg.dp_wr && (s_reg.dp_idx == `RTCC_IDX_CTRL);
  assign wr_load = wr_ctrl && wd[`RTCC_CTRL_LOAD];
  assign wr_snap = wr_ctrl && wd[`RTCC_CTRL_SNAP];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.tick_prev = sync_lvl[0];
    s_next.ready = 1'b1;   // Zero wait states
    s_next.resp = 1'b0;    // Always OKAY

    // Data phase register write
    if (s_reg.dp_wr) begin
      if (s_reg.dp_idx <= `RTCC_IDX_BUF3) begin
        s_next.xfer_buf[s_reg.dp_idx[1:0]*8 +: 8] = wd;
      end else if (s_reg.dp_idx >= `RTCC_IDX_ALM0 && s_reg.dp_idx <= `RTCC_IDX_ALM3) begin
        // Software is expected to have disabled alarms first
        s_next.alarm_val[s_reg.dp_idx[1:0]*8 +: 8] = wd;
      end else if (s_reg.dp_idx == `RTCC_IDX_CTRL) begin
        s_next.osc_en = wd[`RTCC_CTRL_OSC_EN];
        s_next.miss_en = wd[`RTCC_CTRL_MISS_EN];
        if (!wd[`RTCC_CTRL_OSC_FAIL]) begin
          s_next.osc_fail = 1'b0;        // Writing 0 clears the fail flag
        end
        s_next.run = wd[`RTCC_CTRL_RUN];
        s_next.alarm_en = wd[`RTCC_CTRL_ALARM_EN];
        s_next.alarm_flag = 1'b0;
        s_next.auto_rst = wd[`RTCC_CTRL_ALARM_FLAG];
      end else if (s_reg.dp_idx == `RTCC_IDX_OSC) begin
        // Low nibble is not stored at all
        s_next.agc_en = wd[`RTCC_OSC_AGC];
        s_next.osc_mode_select = wd[`RTCC_OSC_MODE];
        s_next.bias_x2 = wd[`RTCC_OSC_BIAS];
      end else if (s_reg.dp_idx == `RTCC_IDX_IRQ_EN) begin
        s_next.irq_en = wd[3:0];
      end
    end

    // RTC tick: transfers complete and the timer moves
    if (tick) begin
      s_next.timer = t_next;
      if (s_reg.snap_req) begin
        s_next.xfer_buf = s_reg.timer;   // Snapshot beats a same-cycle write
      end
      s_next.alarm_flag = alarm_hit;     // Old flag drops at the next tick
      s_next.ar_pend = alarm_hit && s_reg.auto_rst;
    end

    // Requests hold until the tick that performs them; a new write wins
    s_next.load_req = (s_reg.load_req && !tick) || wr_load;
    s_next.snap_req = (s_reg.snap_req && !tick) || wr_snap;

    // Fail flag only means something while the oscillator is on, so the
    // detector is ignored otherwise; set wins over a clearing write.
    if (s_reg.osc_en && s_reg.miss_en && sync_lvl[1]) begin
      s_next.osc_fail = 1'b1;
    end

    // Sticky interrupt status: set wins over the clear register
    begin
      evt = 4'h0;
      clr = 4'h0;
      evt[`RTCC_EVT_ALARM] = alarm_hit;
      evt[`RTCC_EVT_FAIL] = s_next.osc_fail && !s_reg.osc_fail;
      evt[`RTCC_EVT_LOAD] = tick && s_reg.load_req;
      evt[`RTCC_EVT_SNAP] = tick && s_reg.snap_req;
      if (s_reg.dp_wr && s_reg.dp_idx == `RTCC_IDX_IRQ_CLR) begin
        clr = wd[3:0];
      end
      s_next.irq_stat = (s_reg.irq_stat & ~clr) | evt;
      s_next.irq = |(s_next.irq_stat & s_next.irq_en);
    end

    // Address phase: latch write target, prepare read word
    s_next.dp_wr = addr_ok && HWRITE_I;
    if (addr_ok) begin
      s_next.dp_idx = HADDR_I[7:2];
      if (!HWRITE_I) begin
        s_next.rdata = read_word(HADDR_I[7:2], s_reg, sync_lvl[2]);
      end
    end
  end

  // Non-sequential or sequential transfer to this slave
  // Addresses above the map alias nothing: upper bits must be zero
  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1] && (HADDR_I[31:8] == 24'h00_0000);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_reg <= '0;
      s_reg.ready <= 1'b1;
      s_reg.irq_en <= `RTCC_IRQ_EN_RST;
      {s_reg.agc_en, s_reg.osc_mode_select, s_reg.bias_x2} <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign HRDATA_O = s_reg.rdata;
  assign HREADYOUT_O = s_reg.ready;
  assign HRESP_O = s_reg.resp;
  assign TIMER_O = s_reg.timer;
  assign ALARM_O = s_reg.alarm_flag;
  assign OSC_EN_O = s_reg.osc_en;
  assign MISS_DET_EN_O = s_reg.miss_en;
  assign OSC_AGC_EN_O = s_reg.agc_en;
  assign OSC_XTAL_MODE_O = s_reg.osc_mode_select;
  assign OSC_BIAS_X2_O = s_reg.bias_x2;
  assign IRQ_O = s_reg.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Read of a given register in address phase
  logic rd_ctrl;
  logic rd_osc;
  assign rd_ctrl = addr_ok && !HWRITE_I && HADDR_I[7:2] == `RTCC_IDX_CTRL;
  assign rd_osc = addr_ok && !HWRITE_I && HADDR_I[7:2] == `RTCC_IDX_OSC;

  a_timer_hold: assert property (tick && !s_reg.run && !s_reg.load_req && !s_reg.ar_pend
    |=> TIMER_O == $past(TIMER_O)) else $error("stopped timer moved");
  a_timer_count: assert property (tick && s_reg.run && !s_reg.load_req && !s_reg.ar_pend
    |=> TIMER_O == $past(TIMER_O) + 32'h0000_0001) else $error("running timer missed step");
  a_flag_write_clear: assert property (wr_ctrl && !alarm_hit |=> !ALARM_O)
    else $error("alarm flag survived control write");
  a_ctrl_read_flag: assert property (rd_ctrl ##1 HREADYOUT_O
    |-> HRDATA_O[`RTCC_CTRL_ALARM_FLAG] == $past(s_reg.alarm_flag)) else $error("bad flag read");
  a_load_complete: assert property (tick && s_reg.load_req && !wr_load
    |=> TIMER_O == $past(s_reg.xfer_buf) && !s_reg.load_req) else $error("load not done");
  a_snap_complete: assert property (tick && s_reg.snap_req && !wr_snap
    |=> s_reg.xfer_buf == $past(TIMER_O) && !s_reg.snap_req) else $error("snapshot not done");
  a_flag_short: assert property (ALARM_O && tick && !alarm_hit |=> !ALARM_O)
    else $error("alarm flag outlived its tick");
  a_osc_low_zero: assert property (rd_osc |=> HRDATA_O[3:0] == 4'h0)
    else $error("oscillator low nibble not zero");
  a_amp_valid_read: assert property (rd_osc |=> HRDATA_O[`RTCC_OSC_AMPV] == $past(sync_lvl[2]))
    else $error("amplitude valid misread");
  a_alarm_match: assert property (tick && s_reg.alarm_en && t_next == s_reg.alarm_val
    && t_next != TIMER_O |=> ALARM_O ##0 TIMER_O == s_reg.alarm_val) else $error("alarm missed");
  // The gap to the next tick is unbounded in system cycles, so the
  // auto-reset is checked in three steps: scheduled, held, performed.
  a_auto_reset: assert property (alarm_hit && s_reg.auto_rst |=> s_reg.ar_pend)
    else $error("auto reset not scheduled");
  a_auto_pend_hold: assert property (s_reg.ar_pend && !tick |=> s_reg.ar_pend)
    else $error("auto reset dropped before its tick");
  a_auto_zero: assert property (tick && s_reg.ar_pend && !s_reg.load_req
    |=> TIMER_O == 32'h0000_0000) else $error("auto reset missed");
  a_autorst_store: assert property (wr_ctrl && !alarm_hit
    |=> s_reg.auto_rst == $past(wd[`RTCC_CTRL_ALARM_FLAG]) && !ALARM_O) else $error("auto reset store");
  a_req_held: assert property (s_reg.load_req && !tick |=> s_reg.load_req)
    else $error("load request dropped early");

  c_alarm: cover property (alarm_hit ##1 ALARM_O);
  c_auto_reset: cover property (s_reg.ar_pend && tick ##1 TIMER_O == 32'h0000_0000);
  c_load: cover property (tick && s_reg.load_req);
  c_irq: cover property (IRQ_O);

endmodule

// >>> test/tb.sv
// Self-checking testbench of the RTC control and oscillator register block
`timescale 1ns/100ps
`include "rtcc_consts.svh"

module tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;            // System clock, 20 MHz
  logic rst_n_i = 1'b0;           // Reset, active low
  logic hsel_i = 1'b0;            // Bus select
  logic [31:0] haddr_i = 32'h0;   // Byte address
  logic [1:0] htrans_i = 2'h0;    // IDLE when no transfer
  logic hwrite_i = 1'b0;          // Direction
  logic [2:0] hsize_i = 3'h2;     // Always a whole word
  logic [31:0] hwdata_i = 32'h0;  // Write data
  logic rtc_tick_i = 1'b0;        // RTC clock level
  logic osc_missing_i = 1'b0;     // Missing-clock detector level
  logic osc_amp_ok_i = 1'b0;      // Amplitude detector level
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o;
  wire logic hresp_o;
  wire logic [31:0] timer_o;
  wire logic alarm_o;
  wire logic osc_en_o, miss_det_en_o, osc_agc_en_o, osc_xtal_mode_o, osc_bias_x2_o, irq_o;
  int n_fail = 0;                 // Mismatches
  int checks_done = 0;            // Comparisons made
  int cycles = 0;                 // Watchdog count

  always #25 mclk_i = ~mclk_i;

  rtcc_core uut (
    .MCLK_I(mclk_i), .RST_N_I(rst_n_i), .HSEL_I(hsel_i), .HADDR_I(haddr_i),
    .HTRANS_I(htrans_i), .HWRITE_I(hwrite_i), .HSIZE_I(hsize_i), .HWDATA_I(hwdata_i),
    .HREADY_I(hreadyout_o), .HRDATA_O(hrdata_o), .HREADYOUT_O(hreadyout_o),
    .HRESP_O(hresp_o), .RTC_TICK_I(rtc_tick_i), .OSC_MISSING_I(osc_missing_i),
    .OSC_AMP_OK_I(osc_amp_ok_i), .TIMER_O(timer_o), .ALARM_O(alarm_o),
    .OSC_EN_O(osc_en_o), .MISS_DET_EN_O(miss_det_en_o), .OSC_AGC_EN_O(osc_agc_en_o),
    .OSC_XTAL_MODE_O(osc_xtal_mode_o), .OSC_BIAS_X2_O(osc_bias_x2_o), .IRQ_O(irq_o)
  );

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  // Compare and count; four-state compare so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run; the only place the run stops
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Single word transfer; entered just after a rising edge, no cycle count assumed
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [31:0] rd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, idx, 2'h0};
    hwrite_i <= wr;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, wd};
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    xfer(idx, 1'b1, d, unused);
  endtask

  // Read and compare the whole word
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(idx, 1'b0, 8'h00, d);
    check(d, exp);
  endtask

  // One RTC cycle; long enough for the two-flop synchroniser and the edge detect
  task automatic tick();
    rtc_tick_i <= 1'b1;
    idle(4);
    rtc_tick_i <= 1'b0;
    idle(4);
  endtask

  // Fill the transfer buffer, write control, then give the tick that loads
  task automatic load_timer(input logic [31:0] v, input logic [7:0] ctl);
    for (int i = 0; i < 4; i++) begin
      wr(6'(i), v[8*i +: 8]);
    end
    wr(`RTCC_IDX_CTRL, ctl);
    tick();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, bus response and an unmapped place
  task automatic t_reset();
    check({hreadyout_o, hresp_o}, 32'h2);
    rd_chk(`RTCC_IDX_CTRL, 32'h0);
    rd_chk(`RTCC_IDX_OSC, 32'h0);
    rd_chk(`RTCC_IDX_IRQ_EN, 32'h0);
    wr(6'h3f, 8'hff);
    rd_chk(6'h3f, 32'h0);
  endtask

  // Oscillator settings drive their pins; low nibble stays zero
  task automatic t_osc();
    wr(`RTCC_IDX_OSC, 8'hff);
    rd_chk(`RTCC_IDX_OSC, 32'he0);
    check({osc_agc_en_o, osc_xtal_mode_o, osc_bias_x2_o}, 32'h7);
    for (int b = 5; b < 8; b++) begin
      wr(`RTCC_IDX_OSC, 8'h01 << b);
      idle(1);
      check({osc_agc_en_o, osc_xtal_mode_o, osc_bias_x2_o}, 32'h1 << (b - 5));
    end
    osc_amp_ok_i <= 1'b1;
    idle(4);
    rd_chk(`RTCC_IDX_OSC, 32'h90);
    osc_amp_ok_i <= 1'b0;
    idle(4);
    wr(`RTCC_IDX_OSC, 8'h00);
    rd_chk(`RTCC_IDX_OSC, 32'h0);
  endtask

  // Load, run, stop and snapshot
  task automatic t_load_run_snap();
    load_timer(32'h12345678, 8'h02);
    check(timer_o, 32'h12345678);
    rd_chk(`RTCC_IDX_CTRL, 32'h0);
    wr(`RTCC_IDX_CTRL, 8'h12);
    rd_chk(`RTCC_IDX_CTRL, 32'h12);
    tick();
    check(timer_o, 32'h12345678);
    wr(`RTCC_IDX_CTRL, 8'h10);
    tick();
    check(timer_o, 32'h12345679);
    wr(`RTCC_IDX_CTRL, 8'h11);
    tick();
    check(timer_o, 32'h1234567a);
    rd_chk(`RTCC_IDX_BUF0, 32'h79);
    wr(`RTCC_IDX_CTRL, 8'h01);
    rd_chk(`RTCC_IDX_CTRL, 32'h01);
    tick();
    check(timer_o, 32'h1234567a);
    rd_chk(`RTCC_IDX_CTRL, 32'h00);
    for (int i = 0; i < 4; i++) begin
      rd_chk(6'(i), {24'h0, 8'(32'h1234567a >> (8*i))});
    end
    rd_chk(`RTCC_IDX_IRQ_STAT, 32'hc);
  endtask

  // Alarm match, short flag, sticky interrupt: masked and cleared
  task automatic t_alarm();
    load_timer(32'h000000fe, 8'h02);
    wr(`RTCC_IDX_ALM0, 8'h00);
    wr(`RTCC_IDX_ALM0 + 6'h1, 8'h01);
    wr(`RTCC_IDX_ALM0 + 6'h2, 8'h00);
    wr(`RTCC_IDX_ALM3, 8'h00);
    wr(`RTCC_IDX_IRQ_CLR, 8'h0f);
    wr(`RTCC_IDX_IRQ_EN, 8'h01);
    wr(`RTCC_IDX_CTRL, 8'h18);
    tick();
    check({timer_o[15:0], 15'h0, alarm_o}, {16'h00ff, 16'h0});
    tick();
    check({timer_o[15:0], 14'h0, alarm_o, irq_o}, {16'h0100, 16'h3});
    rd_chk(`RTCC_IDX_CTRL, 32'h1c);
    rd_chk(`RTCC_IDX_IRQ_STAT, 32'h1);
    tick();
    check({alarm_o, irq_o}, 32'h1);
    wr(`RTCC_IDX_IRQ_EN, 8'h00);
    idle(2);
    check(irq_o, 32'h0);
    wr(`RTCC_IDX_IRQ_EN, 8'h01);
    idle(2);
    check(irq_o, 32'h1);
    wr(`RTCC_IDX_IRQ_CLR, 8'h01);
    idle(2);
    check(irq_o, 32'h0);
    rd_chk(`RTCC_IDX_IRQ_STAT, 32'h0);
  endtask

  // Auto-reset after a match; a control write drops the flag but never sets it
  task automatic t_auto_reset();
    load_timer(32'h000000ff, 8'h1e);
    check(timer_o, 32'h000000ff);
    tick();
    check(alarm_o, 32'h1);
    wr(`RTCC_IDX_CTRL, 8'h1c);
    idle(2);
    check(alarm_o, 32'h0);
    rd_chk(`RTCC_IDX_CTRL, 32'h18);
    tick();
    check(timer_o, 32'h0);
    wr(`RTCC_IDX_CTRL, 8'h00);
  endtask

  // Oscillator fail flag with detector enabled, cleared by writing zero
  task automatic t_osc_fail();
    wr(`RTCC_IDX_IRQ_CLR, 8'h0f);
    wr(`RTCC_IDX_CTRL, 8'hc0);
    osc_missing_i <= 1'b1;
    idle(4);
    check({osc_en_o, miss_det_en_o}, 32'h3);
    rd_chk(`RTCC_IDX_CTRL, 32'he0);
    rd_chk(`RTCC_IDX_IRQ_STAT, 32'h2);
    osc_missing_i <= 1'b0;
    idle(4);
    wr(`RTCC_IDX_CTRL, 8'hc0);
    rd_chk(`RTCC_IDX_CTRL, 32'hc0);
    wr(`RTCC_IDX_CTRL, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  // Whole run is a few hundred cycles; the ceiling leaves a wide margin
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    idle(8);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_osc();
    t_load_run_snap();
    t_alarm();
    t_auto_reset();
    t_osc_fail();
    idle(2);
    results();
  end
endmodule
